// *** logic/isr_status_core.sv ***
// status byte, event register, masks, error queue and save/recall/reset of setpoints
// assumes: commands arrive parsed, one per cycle while cmd_ready_o is high
//
// What this block does
// RL1 - master summary, bit 6, is unlatched OR of status bits enabled by service mask
// RL2 - event summary bit 5 set while any enabled event status bit is set
// RL3 - message available bit 4 follows a waiting response message
// RL4 - clear-status zeroes event register, status byte and error queue
// RL5 - event register query returns the value and then clears it
// RL6 - event bits: 0 done, 2 query, 3 device, 4 exec, 5 command, 7 power on
// RL7 - power-on event bit set on every reset
// RL8 - eight-bit event enable mask, writable and readable, same layout
// RL9 - status byte query leaves status byte unchanged
// RL10 - message available cleared at power on and on clear-status
// RL11 - status byte: bit 4 message, bit 5 event summary, bit 6 master summary
// RL12 - service mask holds only bits 4 and 5, enabling summary inputs
// RL13 - service mask of zero never raises a service request
// RL14 - save stores five setpoints into locations 0 to 99
// RL15 - recall aborts first, then restores saved setpoints
// RL16 - power-up recalls the location active before switch-off
// RL17 - reset command aborts, output off, levels zero, limits 110% of full scale
// RL18 - identify returns three fields: maker, model, serial
// RL19 - error groups set event bits 5, 4, 3, 2 for -100s to -400s
// RL20 - full error queue drops new errors and reports -350
// RL21 - unused bits read zero, writes to them ignored
// RL22 - master summary excludes itself from its own OR
`timescale 1ns/1ps
module isr_status_core #(
  parameter logic [15:0] MAKER_CODE = 16'h0A01,  // arbitrary value
  parameter logic [15:0] MODEL_CODE = 16'h0B02,  // arbitrary value
  parameter logic [15:0] SERIAL_CODE = 16'h0C03, // arbitrary value
  parameter int unsigned ERRQ_DEPTH = isr_pkg::ERRQ_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire isr_pkg::isr_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output isr_pkg::isr_rsp_t rsp_o,
  input wire logic op_complete_i,
  input wire logic err_valid_i,
  input wire logic [15:0] err_code_i,
  input wire logic msg_waiting_i,
  output logic flush_o,
  input wire isr_pkg::isr_setpoint_t live_setpoint_i,
  input wire logic [isr_pkg::LOC_W-1:0] boot_loc_i,
  output logic restore_valid_o,
  output isr_pkg::isr_setpoint_t restore_o,
  output logic abort_o,
  output logic defaults_o,
  output logic [isr_pkg::LOC_W-1:0] active_loc_o,
  output logic [7:0] status_byte_o,
  output logic service_req_o
);

  if (ERRQ_DEPTH < 2) begin : g_depth_check
    $error("error queue too shallow");
  end

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_IDENT_MODEL,
    ST_IDENT_SERIAL,
    ST_RESTORE
  } isr_state_t;

  isr_state_t state_reg, state_next;
  logic [7:0] event_status_reg, event_status_next, ev_mask_next, srv_mask_next;
  logic [7:0] event_enable_mask_reg, service_request_mask_reg, status_byte_reg, status_byte_next;
  logic [7:0] err_events, new_events;
  isr_pkg::isr_setpoint_t mem [isr_pkg::NUM_LOCATIONS];
  isr_pkg::isr_setpoint_t mem_rd_reg, restore_reg;
  logic [isr_pkg::LOC_W-1:0] loc_reg, rd_loc;
  logic [15:0] q_code, q_head;
  logic take, loc_ok, q_push, q_empty, clear_now, msg_avail_reg;
  logic rsp_valid_reg, restore_valid_reg, abort_reg, defaults_reg, flush_reg, ready_reg, srq_reg;
  isr_pkg::isr_rsp_t rsp_reg;

  assign take = cmd_valid_i && ready_reg;
  assign clear_now = take && cmd_i.op == isr_pkg::ISR_OP_CLEAR_STATUS;
  assign loc_ok = cmd_i.arg < 16'(isr_pkg::NUM_LOCATIONS);
  // next mask values, so a summary never lags a mask write
  assign ev_mask_next = (take && cmd_i.op == isr_pkg::ISR_OP_WRITE_EVENT_MASK) ?
    (cmd_i.arg[7:0] & isr_pkg::EV_USED_MASK) : event_enable_mask_reg; // [RL8] [RL21]
  assign srv_mask_next = (take && cmd_i.op == isr_pkg::ISR_OP_WRITE_SERVICE_MASK) ?
    (cmd_i.arg[7:0] & isr_pkg::SRV_USED_MASK) : service_request_mask_reg; // [RL12] [RL21]

  // map an error code to its group bit
  function automatic logic [7:0] group_bit(input logic [15:0] code);
    logic signed [15:0] c;
    c = signed'(code);
    group_bit = 8'h00;
    if (c <= -16'sd100 && c >= -16'sd199) begin
      group_bit[isr_pkg::EV_CMD_ERR] = 1'b1;
    end else if (c <= -16'sd200 && c >= -16'sd299) begin
      group_bit[isr_pkg::EV_EXEC_ERR] = 1'b1;
    end else if (c <= -16'sd300 && c >= -16'sd399) begin
      group_bit[isr_pkg::EV_DEVICE_ERR] = 1'b1;
    end else if (c <= -16'sd400 && c >= -16'sd499) begin
      group_bit[isr_pkg::EV_QUERY_ERR] = 1'b1;
    end
  endfunction : group_bit

  // a bad location raises an execution error of its own; it wins the queue slot
  always_comb begin
    q_push = err_valid_i;
    q_code = err_code_i;
    if (take && !loc_ok && (cmd_i.op == isr_pkg::ISR_OP_SAVE || cmd_i.op == isr_pkg::ISR_OP_RECALL)) begin
      q_push = 1'b1;
      q_code = isr_pkg::ERR_OUT_OF_RANGE;
    end
  end

  always_comb begin
    err_events = (err_valid_i ? group_bit(err_code_i) : 8'h00) | (q_push ? group_bit(q_code) : 8'h00); // [RL19]
    new_events = err_events;
    new_events[isr_pkg::EV_OP_COMPLETE] = op_complete_i;
  end

  isr_error_queue #(
    .DEPTH(ERRQ_DEPTH)
  ) u_errq (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .push_i(q_push),
    .code_i(q_code),
    .pop_i(take && cmd_i.op == isr_pkg::ISR_OP_READ_ERROR),
    .clear_i(clear_now), // [RL4]
    .head_o(q_head),
    .empty_o(q_empty)
  );

  // event register: new events win over read-clear and clear-status
  always_comb begin
    event_status_next = event_status_reg;
    if (clear_now || (take && cmd_i.op == isr_pkg::ISR_OP_READ_EVENTS)) begin
      event_status_next = 8'h00; // [RL4] [RL5]
    end
    event_status_next = (event_status_next | new_events) & isr_pkg::EV_USED_MASK; // [RL6] [RL21]
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      event_status_reg <= isr_pkg::EV_RESET_VALUE; // [RL7]
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      event_enable_mask_reg <= isr_pkg::MASK_RESET_VALUE;
      service_request_mask_reg <= isr_pkg::MASK_RESET_VALUE;
    end else begin
      event_enable_mask_reg <= ev_mask_next;
      service_request_mask_reg <= srv_mask_next;
    end
  end

  // message available follows the output buffer, held low while the flush empties it
  always_ff @(posedge core_clk_i) begin
    if (rst_i || clear_now) begin
      msg_avail_reg <= 1'b0; // [RL10]
    end else begin
      msg_avail_reg <= msg_waiting_i && !flush_reg; // [RL3] [RL10]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= clear_now; // [RL4]
    end
  end

  // status byte is rebuilt every cycle, reading it never alters it
  always_comb begin
    status_byte_next = 8'h00; // [RL21]
    status_byte_next[isr_pkg::SB_MSG_AVAIL] = msg_avail_reg && !clear_now; // [RL11]
    status_byte_next[isr_pkg::SB_EVENT_SUM] = |(event_status_next & ev_mask_next); // [RL2]
    // only bits 4 and 5 can pass the mask, so bit 6 never feeds itself
    status_byte_next[isr_pkg::SB_MASTER_SUM] =
      |(status_byte_next & srv_mask_next & isr_pkg::SRV_USED_MASK); // [RL1] [RL22]
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_byte_reg <= 8'h00;
      srq_reg <= 1'b0;
    end else begin
      status_byte_reg <= status_byte_next; // [RL9]
      srq_reg <= status_byte_next[isr_pkg::SB_MASTER_SUM]; // [RL13]
    end
  end

  // setpoint memory
  always_ff @(posedge core_clk_i) begin
    if (take && cmd_i.op == isr_pkg::ISR_OP_SAVE && loc_ok) begin
      mem[cmd_i.arg[isr_pkg::LOC_W-1:0]] <= live_setpoint_i; // [RL14]
    end
  end

  always_comb begin
    if (state_reg == ST_BOOT) begin
      rd_loc = (boot_loc_i < isr_pkg::LOC_W'(isr_pkg::NUM_LOCATIONS)) ? boot_loc_i : '0;
    end else begin
      rd_loc = cmd_i.arg[isr_pkg::LOC_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    mem_rd_reg <= mem[rd_loc];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      loc_reg <= '0;
    end else if (state_reg == ST_BOOT) begin
      loc_reg <= rd_loc; // [RL16]
    end else if (take && loc_ok && (cmd_i.op == isr_pkg::ISR_OP_SAVE || cmd_i.op == isr_pkg::ISR_OP_RECALL)) begin
      loc_reg <= cmd_i.arg[isr_pkg::LOC_W-1:0];
    end
  end

  // sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: begin
        state_next = ST_RESTORE; // [RL16]
      end
      ST_IDLE: begin
        if (take && cmd_i.op == isr_pkg::ISR_OP_IDENTIFY) begin
          state_next = ST_IDENT_MODEL;
        end else if (take && cmd_i.op == isr_pkg::ISR_OP_RECALL && loc_ok) begin
          state_next = ST_RESTORE;
        end
      end
      ST_IDENT_MODEL: begin
        state_next = ST_IDENT_SERIAL;
      end
      ST_IDENT_SERIAL: begin
        state_next = ST_IDLE;
      end
      ST_RESTORE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_BOOT;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
    end
  end

  // abort goes out with the recall or reset command, before a recall's restore and in the same cycle as a reset's defaults
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      abort_reg <= 1'b0;
      defaults_reg <= 1'b0;
      restore_valid_reg <= 1'b0;
      restore_reg <= '0;
    end else begin
      abort_reg <= take && ((cmd_i.op == isr_pkg::ISR_OP_RECALL && loc_ok)
                            || cmd_i.op == isr_pkg::ISR_OP_RESET); // [RL15] [RL17]
      defaults_reg <= take && cmd_i.op == isr_pkg::ISR_OP_RESET; // [RL17]
      restore_valid_reg <= 1'b0;
      if (state_reg == ST_RESTORE) begin
        restore_valid_reg <= 1'b1;
        restore_reg <= mem_rd_reg; // [RL15] [RL16]
      end else if (take && cmd_i.op == isr_pkg::ISR_OP_RESET) begin
        restore_valid_reg <= 1'b1;
        restore_reg.volt <= 16'h0000;
        restore_reg.curr <= 16'h0000;
        restore_reg.period_setting <= 16'h0000;
        restore_reg.volt_limit <= isr_pkg::LIMIT_110; // [RL17]
        restore_reg.curr_limit <= isr_pkg::LIMIT_110; // [RL17]
      end
    end
  end

  // answers to queries
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      rsp_valid_reg <= 1'b0;
      rsp_reg.field <= 2'd0;
      rsp_reg.last <= 1'b1;
      if (state_reg == ST_IDENT_MODEL) begin
        rsp_valid_reg <= 1'b1;
        rsp_reg <= '{data: MODEL_CODE, field: 2'd1, last: 1'b0}; // [RL18]
      end else if (state_reg == ST_IDENT_SERIAL) begin
        rsp_valid_reg <= 1'b1;
        rsp_reg <= '{data: SERIAL_CODE, field: 2'd2, last: 1'b1}; // [RL18]
      end else if (take) begin
        rsp_valid_reg <= 1'b1;
        case (cmd_i.op)
          isr_pkg::ISR_OP_READ_EVENTS: rsp_reg.data <= {8'h00, event_status_reg}; // [RL5]
          isr_pkg::ISR_OP_READ_EVENT_MASK: rsp_reg.data <= {8'h00, event_enable_mask_reg}; // [RL8]
          isr_pkg::ISR_OP_READ_STATUS: rsp_reg.data <= {8'h00, status_byte_reg}; // [RL9]
          isr_pkg::ISR_OP_READ_SERVICE_MASK: rsp_reg.data <= {8'h00, service_request_mask_reg}; // [RL12]
          isr_pkg::ISR_OP_READ_ERROR: rsp_reg.data <= q_head;
          isr_pkg::ISR_OP_IDENTIFY: begin
            rsp_reg.data <= MAKER_CODE; // [RL18]
            rsp_reg.last <= 1'b0;
          end
          default: rsp_valid_reg <= 1'b0;
        endcase
      end
    end
  end

  assign cmd_ready_o = ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_o = rsp_reg;
  assign flush_o = flush_reg;
  assign restore_valid_o = restore_valid_reg;
  assign restore_o = restore_reg;
  assign abort_o = abort_reg;
  assign defaults_o = defaults_reg;
  assign active_loc_o = loc_reg;
  assign status_byte_o = status_byte_reg;
  assign service_req_o = srq_reg;

  chk_pon_after_reset: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> event_status_reg[isr_pkg::EV_POWER_ON]) else $error("power-on bit missing"); // [RL7]
  chk_read_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && cmd_i.op == isr_pkg::ISR_OP_READ_EVENTS && !op_complete_i && !q_push
    |=> event_status_reg == 8'h00 && rsp_o.data[7:0] == $past(event_status_reg))
    else $error("event read did not clear"); // [RL5]
  chk_master_sum: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_byte_o[6] == |(status_byte_o[5:4] & service_request_mask_reg[5:4]))
    else $error("master summary wrong"); // [RL1]
  chk_event_sum: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_byte_o[5] == |(event_status_reg & event_enable_mask_reg)) else $error("event summary wrong"); // [RL2]
  chk_unused_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_byte_o[3:0] == 4'h0 && !status_byte_o[7] && (event_status_reg & ~isr_pkg::EV_USED_MASK) == 8'h00)
    else $error("unused bit set"); // [RL21]
  chk_no_srq_masked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    service_request_mask_reg == 8'h00 |-> !service_req_o) else $error("request with zero mask"); // [RL13]
  chk_clear_all: assert property (@(posedge core_clk_i) disable iff (rst_i)
    clear_now && !op_complete_i && !err_valid_i |=> event_status_reg == 8'h00 && !status_byte_o[4] && q_empty)
    else $error("clear-status incomplete"); // [RL4]
  chk_recall_order: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && cmd_i.op == isr_pkg::ISR_OP_RECALL && loc_ok |=> abort_o && !restore_valid_o ##1 restore_valid_o)
    else $error("recall sequence wrong"); // [RL15]
  chk_reset_limits: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && cmd_i.op == isr_pkg::ISR_OP_RESET |=> abort_o && defaults_o && restore_valid_o
    && restore_o.volt_limit == isr_pkg::LIMIT_110 && restore_o.volt == 16'h0000)
    else $error("reset defaults wrong"); // [RL17]
  chk_cmd_error_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    err_valid_i && signed'(err_code_i) <= -16'sd100 && signed'(err_code_i) >= -16'sd199
    |=> event_status_reg[isr_pkg::EV_CMD_ERR])
    else $error("command error bit not set"); // [RL19]

  cov_recall: cover property (@(posedge core_clk_i) disable iff (rst_i) restore_valid_o && !defaults_o);
  cov_identify: cover property (@(posedge core_clk_i) disable iff (rst_i) rsp_valid_o && rsp_o.field == 2'd2);
  cov_service_req: cover property (@(posedge core_clk_i) disable iff (rst_i) service_req_o);

endmodule : isr_status_core

// *** logic/isr_pkg.sv ***
// shared types and constants of the status-reporting and common-command block
// assumes: one 50 MHz clock, commands already parsed into opcodes
package isr_pkg;

  localparam int unsigned CLK_MHZ = 50;

  // command opcodes, one per common command
  typedef enum logic [3:0] {
    ISR_OP_NONE,
    ISR_OP_CLEAR_STATUS,
    ISR_OP_READ_EVENTS,
    ISR_OP_WRITE_EVENT_MASK,
    ISR_OP_READ_EVENT_MASK,
    ISR_OP_READ_STATUS,
    ISR_OP_WRITE_SERVICE_MASK,
    ISR_OP_READ_SERVICE_MASK,
    ISR_OP_IDENTIFY,
    ISR_OP_SAVE,
    ISR_OP_RECALL,
    ISR_OP_RESET,
    ISR_OP_READ_ERROR
  } isr_op_t;

  typedef struct packed {
    isr_op_t op;
    logic [15:0] arg;
  } isr_cmd_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] field;
    logic last;
  } isr_rsp_t;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] volt_limit;
    logic [15:0] curr_limit;
    logic [15:0] period_setting;
  } isr_setpoint_t;

  // event status bit positions
  localparam int unsigned EV_OP_COMPLETE = 0;
  localparam int unsigned EV_QUERY_ERR = 2;
  localparam int unsigned EV_DEVICE_ERR = 3;
  localparam int unsigned EV_EXEC_ERR = 4;
  localparam int unsigned EV_CMD_ERR = 5;
  localparam int unsigned EV_POWER_ON = 7;
  localparam logic [7:0] EV_USED_MASK = 8'hBD;
  localparam logic [7:0] EV_RESET_VALUE = 8'h80;

  // status byte bit positions
  localparam int unsigned SB_MSG_AVAIL = 4;
  localparam int unsigned SB_EVENT_SUM = 5;
  localparam int unsigned SB_MASTER_SUM = 6;
  localparam logic [7:0] SRV_USED_MASK = 8'h30;
  localparam logic [7:0] MASK_RESET_VALUE = 8'h00;

  // setpoint memory
  localparam int unsigned NUM_LOCATIONS = 100;
  localparam int unsigned LOC_W = 7;

  // error codes
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;
  localparam logic signed [15:0] ERR_OVERFLOW = -16'sd350;
  localparam logic signed [15:0] ERR_OUT_OF_RANGE = -16'sd222;

  // protection limits after reset: 110% of full scale
  localparam int unsigned FULL_SCALE = 32'hE000;
  localparam logic [15:0] LIMIT_110 = 16'(FULL_SCALE * 11 / 10);

  localparam int unsigned ERRQ_DEPTH = 8;

endpackage : isr_pkg

// *** logic/isr_error_queue.sv ***
// error queue: fifo of signed error codes with overflow marker
// assumes: one push and one pop at most per cycle
`timescale 1ns/1ps
module isr_error_queue #(
  parameter int unsigned DEPTH = isr_pkg::ERRQ_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [15:0] code_i,
  input wire logic pop_i,
  input wire logic clear_i,
  output logic [15:0] head_o,
  output logic empty_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
    $error("error queue depth must be a power of two, at least 2");
  end

  logic [15:0] mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  logic do_pop;
  logic do_push;
  logic [15:0] wr_code;

  assign do_pop = pop_i && (cnt_reg != '0);
  // last free slot takes the overflow code, a full queue drops new entries unless one is popped in the same cycle [RL20]
  assign do_push = push_i && (cnt_reg < (PW+1)'(DEPTH) || do_pop);
  assign wr_code = (cnt_reg == (PW+1)'(DEPTH - 1) && !do_pop) ? isr_pkg::ERR_OVERFLOW : code_i;
  assign head_o = (cnt_reg != '0) ? mem[rd_reg] : isr_pkg::ERR_NONE;
  assign empty_o = (cnt_reg == '0);

  always_ff @(posedge core_clk_i) begin
    if (do_push && !clear_i) begin
      mem[wr_reg] <= wr_code;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || clear_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  chk_queue_bounded: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cnt_reg <= (PW+1)'(DEPTH)) else $error("error queue count above depth"); // [RL20]

endmodule : isr_error_queue

// *** test/isr_host_model.sv ***
// host-side output buffer: holds a response message until flushed
// assumes: bench raises post_i for one cycle to queue a message
`timescale 1ns/1ps
module isr_host_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic post_i,
  input wire logic flush_i,
  output logic msg_waiting_o
);
  // flush drops the waiting message, so the level never lingers
  always_ff @(posedge core_clk_i) begin
    if (rst_i || flush_i) begin
      msg_waiting_o <= 1'b0;
    end else if (post_i) begin
      msg_waiting_o <= 1'b1;
    end
  end
endmodule : isr_host_model

// *** test/ieee488_status_reporting_tb.sv ***
// self-checking bench of the status core with a host buffer model
// assumes: inputs driven at falling edge, pulses and responses sampled 1 ns after rising edge, levels checked at falling edge
`timescale 1ns/1ps
module ieee488_status_reporting_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic op_complete_i = 1'b0;
  logic err_valid_i = 1'b0;
  logic post = 1'b0;
  logic msg_waiting;
  logic [15:0] err_code_i = 16'h0000;
  isr_pkg::isr_cmd_t cmd_i = '0;
  isr_pkg::isr_setpoint_t live_setpoint_i = '0;
  logic [6:0] boot_loc_i = 7'h05;
  logic cmd_ready_o, rsp_valid_o, flush_o, restore_valid_o, abort_o, defaults_o, service_req_o;
  isr_pkg::isr_rsp_t rsp_o;
  isr_pkg::isr_setpoint_t restore_o, got_sp;
  logic [6:0] active_loc_o;
  logic [7:0] status_byte_o;
  logic saw_abort, saw_defaults, saw_flush;
  logic [15:0] d;
  int num_errors = 0;
  int comparisons = 0;
  isr_pkg::isr_rsp_t rq[$];

  isr_status_core #(.MAKER_CODE(16'h1234), .MODEL_CODE(16'h5678), // arbitrary values
    .SERIAL_CODE(16'h9ABC), .ERRQ_DEPTH(4)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o), .op_complete_i(op_complete_i), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
    .msg_waiting_i(msg_waiting), .flush_o(flush_o), .live_setpoint_i(live_setpoint_i),
    .boot_loc_i(boot_loc_i), .restore_valid_o(restore_valid_o), .restore_o(restore_o),
    .abort_o(abort_o), .defaults_o(defaults_o), .active_loc_o(active_loc_o),
    .status_byte_o(status_byte_o), .service_req_o(service_req_o));
  isr_host_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .post_i(post), .flush_i(flush_o),
    .msg_waiting_o(msg_waiting));

  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  // pulse and response capture away from both edges
  always @(posedge core_clk_i) begin
    #1;
    if (rsp_valid_o === 1'b1) rq.push_back(rsp_o);
    if (abort_o === 1'b1) saw_abort = 1'b1;
    if (defaults_o === 1'b1) saw_defaults = 1'b1;
    if (flush_o === 1'b1) saw_flush = 1'b1;
    if (restore_valid_o === 1'b1) got_sp = restore_o;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic send(input isr_pkg::isr_op_t op, input logic [15:0] arg);
    int i;
    @(negedge core_clk_i);
    rq.delete();
    saw_abort = 1'b0;
    saw_defaults = 1'b0;
    saw_flush = 1'b0;
    got_sp = 'x;
    cmd_valid_i = 1'b1;
    cmd_i = '{op: op, arg: arg};
    i = 0;
    while (cmd_ready_o !== 1'b1) begin
      i++;
      if (i > 20) begin
        num_errors++;
        $display("[FAIL] %0t command not taken", $time);
        finish_test();
      end
      @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
  endtask : send

  task automatic q(input isr_pkg::isr_op_t op);
    send(op, 16'h0000);
    d = (rq.size() > 0) ? rq[0].data : 16'hxxxx;
  endtask : q

  task automatic pulse(input logic err, input logic [15:0] code);
    @(negedge core_clk_i);
    err_valid_i = err;
    op_complete_i = ~err;
    err_code_i = code;
    @(negedge core_clk_i);
    err_valid_i = 1'b0;
    op_complete_i = 1'b0;
    @(negedge core_clk_i);
  endtask : pulse

  task automatic t_boot();
    chk(active_loc_o, 7'h05, "boot location");
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d, 16'h0080, "power-on event");
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d, 16'h0000, "read clears events");
    $display("boot done");
  endtask : t_boot

  task automatic t_masks();
    send(isr_pkg::ISR_OP_WRITE_EVENT_MASK, 16'h00FF);
    q(isr_pkg::ISR_OP_READ_EVENT_MASK);
    chk(d[7:0], 8'hBD, "event mask");
    send(isr_pkg::ISR_OP_WRITE_SERVICE_MASK, 16'h00FF);
    q(isr_pkg::ISR_OP_READ_SERVICE_MASK);
    chk(d[7:0], 8'h30, "service mask");
    send(isr_pkg::ISR_OP_WRITE_SERVICE_MASK, 16'h0000);
    $display("masks done");
  endtask : t_masks

  task automatic t_summary();
    pulse(1'b0, 16'h0000);
    chk(status_byte_o, 8'h20, "event summary");
    chk(service_req_o, 1'b0, "zero mask no request");
    send(isr_pkg::ISR_OP_WRITE_SERVICE_MASK, 16'h0020);
    chk(status_byte_o, 8'h60, "master summary");
    chk(service_req_o, 1'b1, "service request");
    q(isr_pkg::ISR_OP_READ_STATUS);
    q(isr_pkg::ISR_OP_READ_STATUS);
    chk(d[7:0], 8'h60, "status read keeps");
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d[7:0], 8'h01, "operation complete");
    chk(status_byte_o, 8'h00, "summary drops");
    $display("summary done");
  endtask : t_summary

  task automatic t_clear();
    @(negedge core_clk_i);
    post = 1'b1;
    @(negedge core_clk_i);
    post = 1'b0;
    pulse(1'b1, 16'hFF9C);
    chk(status_byte_o, 8'h70, "message and command error");
    send(isr_pkg::ISR_OP_CLEAR_STATUS, 16'h0000);
    chk(saw_flush, 1'b1, "flush");
    chk(status_byte_o, 8'h00, "status cleared");
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d, 16'h0000, "events cleared");
    q(isr_pkg::ISR_OP_READ_ERROR);
    chk(d, 16'h0000, "queue cleared");
    $display("clear done");
  endtask : t_clear

  task automatic t_overflow();
    repeat (5) pulse(1'b1, 16'hFF9C);
    for (int i = 0; i < 5; i++) begin
      q(isr_pkg::ISR_OP_READ_ERROR);
      chk(d, (i < 3) ? 16'hFF9C : (i == 3) ? 16'hFEA2 : 16'h0000, "error queue");
    end
    $display("overflow done");
  endtask : t_overflow

  task automatic t_store();
    isr_pkg::isr_setpoint_t sp;
    send(isr_pkg::ISR_OP_CLEAR_STATUS, 16'h0000);
    sp = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    live_setpoint_i = sp;
    send(isr_pkg::ISR_OP_SAVE, 16'd99);
    chk(active_loc_o, 7'd99, "save location");
    live_setpoint_i = '0;
    send(isr_pkg::ISR_OP_RECALL, 16'd99);
    chk(saw_abort, 1'b1, "recall abort");
    chk(got_sp, sp, "recall data");
    send(isr_pkg::ISR_OP_SAVE, 16'd100);
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d, 16'h0010, "range error event");
    q(isr_pkg::ISR_OP_READ_ERROR);
    chk(d, 16'hFF22, "range error code");
    send(isr_pkg::ISR_OP_RESET, 16'h0000);
    chk({saw_abort, saw_defaults}, 2'b11, "reset pulses");
    chk(got_sp, {32'h0, isr_pkg::LIMIT_110, isr_pkg::LIMIT_110, 16'h0}, "defaults");
    $display("store done");
  endtask : t_store

  task automatic t_reboot();
    got_sp = 'x;
    boot_loc_i = 7'd99;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    chk(active_loc_o, 7'd99, "reboot location");
    chk(got_sp, {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555}, "reboot recall");
    q(isr_pkg::ISR_OP_READ_EVENTS);
    chk(d, 16'h0080, "reboot power-on");
    $display("reboot done");
  endtask : t_reboot

  task automatic t_ident();
    q(isr_pkg::ISR_OP_IDENTIFY);
    chk(rq.size(), 3, "identify beats");
    for (int i = 0; i < 3 && i < rq.size(); i++) begin
      chk({rq[i].data, rq[i].field, rq[i].last}, {(i == 0) ? 16'h1234 : (i == 1) ? 16'h5678 : 16'h9ABC,
        2'(i), i == 2}, "identify field");
    end
    $display("identify done");
  endtask : t_ident

  initial begin
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    t_boot();
    t_masks();
    t_summary();
    t_clear();
    t_overflow();
    t_store();
    t_reboot();
    t_ident();
    finish_test();
  end
endmodule : ieee488_status_reporting_tb
